// ==== hw/fsl_pkg.sv ====
package fsl_pkg;
  // clock and time base
  localparam longint unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned MINUTE_S = 60;
  localparam longint unsigned MIN_CYC = MINUTE_S * CLK_HZ;
  localparam logic [5:0] HOUR_MIN = 6'h3c;
  localparam logic [5:0] HOUR_LAST = HOUR_MIN - 6'h01;
  localparam logic [2:0] FORCE_MIN = 3'h5;
  localparam logic [2:0] FORCE_LAST = FORCE_MIN - 3'h1;
  localparam logic [3:0] STOP_PCT_DIV = 4'ha;

  // hourly start slots
  localparam int SLOTS = 16;
  localparam int CNT_W = 5;

  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MAX = 8'h04;
  localparam logic [7:0] A_INTERVAL = 8'h08;
  localparam logic [7:0] A_THRESH = 8'h0c;
  localparam logic [7:0] A_NOMINAL = 8'h10;
  localparam logic [7:0] A_EVT_EN = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_TOTAL = 8'h1c;
  localparam logic [7:0] A_ELAPSED = 8'h20;
  localparam logic [7:0] A_TRIP_TS = 8'h24;
  localparam logic [7:0] A_TRIP_REC = 8'h28;

  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_FORCE = 1;
  localparam int EV_ALR_ON = 0;
  localparam int EV_ALR_OFF = 1;
  localparam int EV_INH_ON = 2;
  localparam int EV_INH_OFF = 3;
  localparam int ST_RUN = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_INHIBIT = 2;
  localparam int ST_FORCE = 3;
  localparam int ST_CNT_LSB = 8;
  localparam int REC_SINCE_LSB = 16;

  // reset values
  localparam logic [3:0] MAX_RST = 4'h3;
  localparam logic [7:0] INTERVAL_RST = 8'h0a;
  localparam logic [15:0] THRESH_RST = 16'h0600;
  localparam logic [15:0] NOMINAL_RST = 16'h0100;
  localparam logic [3:0] EVT_EN_RST = 4'hf;
endpackage

// ==== hw/fsl_tick.sv ====
`timescale 1ns/1ps
// one-cycle pulse once per minute of hclk
module fsl_tick #(
  parameter longint unsigned MIN_CYC = fsl_pkg::MIN_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // minute pulse
  output logic min_tick
);
  logic [39:0] cnt_q;
  wire wrap = (cnt_q == 40'(MIN_CYC - 1));

  // free-running prescaler, so a timer's first minute may be short
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 40'h0;
      min_tick <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? 40'h0 : cnt_q + 40'h1;
      min_tick <= wrap;
    end
  end
endmodule

// ==== hw/fsl_top.sv ====
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Behaviour
// - start seen when current, below 10% of nominal, rises above start threshold.
// - after a start, current below 10% of nominal means motor stopped.
// - alarm on next-to-last start; held until limit reached or an hour passes.
// - each start raises inhibit for the minimum interval, then releases it.
// - reaching hourly maximum raises inhibit for one hour.
// - common force flag clears itself 5 minutes after last panel press.
// - count of starts within the last hour is readable.
// - minutes elapsed since the latest start are readable.
// - interval setting, in minutes, sets the post-start inhibit length.
// - cumulative start count kept apart from the hourly window.
// - a trip records timestamp, hourly start count and elapsed minutes.
module fsl_top #(
  parameter longint unsigned MIN_CYC = fsl_pkg::MIN_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // measurement and trip record inputs
  input wire logic [15:0] phase_current,
  input wire logic trip_in,
  input wire logic [31:0] trip_stamp,
  input wire logic panel_button,
  // protection outputs
  output logic start_alarm,
  output logic start_inhibit,
  output logic force_flag,
  // events
  output logic alarm_on_event,
  output logic alarm_off_event,
  output logic inhibit_raise_event,
  output logic inhibit_clear_event
);
  localparam int SLOTS = fsl_pkg::SLOTS;
  localparam int CNT_W = fsl_pkg::CNT_W;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [SLOTS-1:0] first_free(input logic [SLOTS-1:0] act);
    logic found;
    found = 1'b0;
    first_free = '0;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (!act[i] && !found)
      begin
        first_free[i] = 1'b1;
        found = 1'b1;
      end
    end
  endfunction

  function automatic logic [CNT_W-1:0] ones(input logic [SLOTS-1:0] v);
    ones = '0;
    for (int i = 0; i < SLOTS; i++)
      ones = ones + CNT_W'(v[i]);
  endfunction

  // minute time base
  logic min_tick;
  fsl_tick #(.MIN_CYC(MIN_CYC)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .min_tick(min_tick)
  );

  // software registers
  logic en_q, wr_pend_q;
  logic [7:0] wr_addr_q, interval_q;
  logic [3:0] max_q, evt_en_q;
  logic [15:0] thresh_q, nominal_q;
  // block state
  logic stopped_q, started_q, lock_q;
  logic [5:0] alarm_age_q, lock_age_q;
  logic [2:0] force_age_q;
  logic [15:0] since_q;
  logic [31:0] total_q, trip_ts_q;
  logic [CNT_W-1:0] trip_cnt_q;
  logic [15:0] trip_since_q;
  logic [SLOTS-1:0] slot_act_q;
  logic [5:0] slot_age_q [SLOTS];
  logic btn_s1_q, btn_s2_q, btn_s3_q, btn_q;

  // bus decode; writes land in the data phase, reads are fetched at address phase
  wire take = hsel & htrans[1] & hready;
  wire wr_ctrl = wr_pend_q & hit(wr_addr_q, fsl_pkg::A_CTRL);
  wire wr_max = wr_pend_q & hit(wr_addr_q, fsl_pkg::A_MAX);
  wire wr_intv = wr_pend_q & hit(wr_addr_q, fsl_pkg::A_INTERVAL);
  wire wr_thr = wr_pend_q & hit(wr_addr_q, fsl_pkg::A_THRESH);
  wire wr_nom = wr_pend_q & hit(wr_addr_q, fsl_pkg::A_NOMINAL);
  wire wr_evt = wr_pend_q & hit(wr_addr_q, fsl_pkg::A_EVT_EN);

  // motor state from current
  wire [19:0] cur_x10 = 20'(phase_current) * 20'(fsl_pkg::STOP_PCT_DIV);
  wire below = cur_x10 < {4'h0, nominal_q};
  wire start_evt = en_q & stopped_q & (phase_current > thresh_q);

  // hourly window bookkeeping
  wire [SLOTS-1:0] alloc = first_free(slot_act_q);
  wire [CNT_W-1:0] hourly_cnt = ones(slot_act_q);
  wire [CNT_W-1:0] next_cnt = hourly_cnt + CNT_W'(1);
  wire [CNT_W-1:0] max_w = CNT_W'(max_q);

  // alarm, lockout and inhibit decisions
  wire alarm_set = start_evt & (max_w > CNT_W'(1)) & (next_cnt == max_w - CNT_W'(1));
  wire alarm_end = min_tick & (alarm_age_q == fsl_pkg::HOUR_LAST);
  wire alarm_clr = (hourly_cnt >= max_w) | alarm_end;
  wire alarm_d = alarm_set | (start_alarm & ~alarm_clr);
  wire lock_set = start_evt & (next_cnt >= max_w);
  wire lock_end = min_tick & (lock_age_q == fsl_pkg::HOUR_LAST);
  wire interval_inh = started_q & (since_q < {8'h0, interval_q});
  wire inhibit_d = en_q & (interval_inh | lock_q);

  // force flag timeout; a write wins over expiry, and a press in that cycle restarts the timer
  wire btn_press = (btn_s2_q == btn_s3_q) & btn_s3_q & ~btn_q;
  wire force_exp = force_flag & min_tick & ~btn_press & (force_age_q == fsl_pkg::FORCE_LAST);
  wire force_d = wr_ctrl ? hwdata[fsl_pkg::CTRL_FORCE] : (force_flag & ~force_exp);

  // read mux
  wire [31:0] status_w = {19'h0, hourly_cnt, 4'h0, force_flag, start_inhibit,
                          start_alarm, ~stopped_q};
  wire [31:0] rec_w = {trip_since_q, 11'h0, trip_cnt_q};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_w =
    hit(ra, fsl_pkg::A_CTRL) ? {30'h0, force_flag, en_q} :
    hit(ra, fsl_pkg::A_MAX) ? {28'h0, max_q} :
    hit(ra, fsl_pkg::A_INTERVAL) ? {24'h0, interval_q} :
    hit(ra, fsl_pkg::A_THRESH) ? {16'h0, thresh_q} :
    hit(ra, fsl_pkg::A_NOMINAL) ? {16'h0, nominal_q} :
    hit(ra, fsl_pkg::A_EVT_EN) ? {28'h0, evt_en_q} :
    hit(ra, fsl_pkg::A_STATUS) ? status_w :
    hit(ra, fsl_pkg::A_TOTAL) ? total_q :
    hit(ra, fsl_pkg::A_ELAPSED) ? {16'h0, since_q} :
    hit(ra, fsl_pkg::A_TRIP_TS) ? trip_ts_q :
    hit(ra, fsl_pkg::A_TRIP_REC) ? rec_w : 32'h0;

  // bus phase tracking and read data; zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      wr_addr_q <= haddr[7:0];
      hrdata <= (take & ~hwrite) ? rd_w : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // settings written by software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_q <= 1'b1;
      max_q <= fsl_pkg::MAX_RST;
      interval_q <= fsl_pkg::INTERVAL_RST;
      thresh_q <= fsl_pkg::THRESH_RST;
      nominal_q <= fsl_pkg::NOMINAL_RST;
      evt_en_q <= fsl_pkg::EVT_EN_RST;
    end
    else
    begin
      if (wr_ctrl)
        en_q <= hwdata[fsl_pkg::CTRL_EN];
      if (wr_max)
        max_q <= hwdata[3:0];
      if (wr_intv)
        interval_q <= hwdata[7:0];
      if (wr_thr)
        thresh_q <= hwdata[15:0];
      if (wr_nom)
        nominal_q <= hwdata[15:0];
      if (wr_evt)
        evt_en_q <= hwdata[3:0];
    end
  end

  // motor stopped flag and start bookkeeping
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stopped_q <= 1'b0;
      started_q <= 1'b0;
      since_q <= 16'h0;
      total_q <= 32'h0;
    end
    else
    begin
      if (start_evt)
        stopped_q <= 1'b0;
      else if (below)
        stopped_q <= 1'b1;
      if (start_evt)
      begin
        started_q <= 1'b1;
        since_q <= 16'h0;
        total_q <= total_q + 32'h1;
      end
      else if (min_tick && since_q != 16'hffff)
        since_q <= since_q + 16'h1;
    end
  end

  // one slot per start in the last hour, freed sixty minutes later
  for (genvar i = 0; i < SLOTS; i++)
  begin : g_slot
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        slot_act_q[i] <= 1'b0;
        slot_age_q[i] <= 6'h0;
      end
      else if (start_evt && alloc[i])
      begin
        slot_act_q[i] <= 1'b1;
        slot_age_q[i] <= 6'h0;
      end
      else if (min_tick && slot_act_q[i])
      begin
        slot_act_q[i] <= (slot_age_q[i] != fsl_pkg::HOUR_LAST);
        slot_age_q[i] <= slot_age_q[i] + 6'h1;
      end
    end
  end

  // alarm and hourly lockout timers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_alarm <= 1'b0;
      alarm_age_q <= 6'h0;
      lock_q <= 1'b0;
      lock_age_q <= 6'h0;
      start_inhibit <= 1'b0;
    end
    else
    begin
      start_alarm <= alarm_d;
      if (alarm_set)
        alarm_age_q <= 6'h0;
      else if (min_tick && start_alarm)
        alarm_age_q <= alarm_age_q + 6'h1;
      if (lock_set)
      begin
        lock_q <= 1'b1;
        lock_age_q <= 6'h0;
      end
      else if (lock_end)
        lock_q <= 1'b0;
      else if (min_tick && lock_q)
        lock_age_q <= lock_age_q + 6'h1;
      start_inhibit <= inhibit_d;
    end
  end

  // panel button: three-stage synchroniser, press counted once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      btn_s3_q <= 1'b0;
      btn_q <= 1'b0;
      force_flag <= 1'b0;
      force_age_q <= 3'h0;
    end
    else
    begin
      btn_s1_q <= panel_button;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
      if (btn_s2_q == btn_s3_q)
        btn_q <= btn_s3_q;
      force_flag <= force_d;
      if (btn_press || wr_ctrl)
        force_age_q <= 3'h0;
      else if (min_tick && force_flag && force_age_q != fsl_pkg::FORCE_LAST)
        force_age_q <= force_age_q + 3'h1;
    end
  end

  // trip record and event pulses
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trip_ts_q <= 32'h0;
      trip_cnt_q <= '0;
      trip_since_q <= 16'h0;
      alarm_on_event <= 1'b0;
      alarm_off_event <= 1'b0;
      inhibit_raise_event <= 1'b0;
      inhibit_clear_event <= 1'b0;
    end
    else
    begin
      if (trip_in)
      begin
        trip_ts_q <= trip_stamp;
        trip_cnt_q <= hourly_cnt;
        trip_since_q <= since_q;
      end
      alarm_on_event <= evt_en_q[fsl_pkg::EV_ALR_ON] & alarm_d & ~start_alarm;
      alarm_off_event <= evt_en_q[fsl_pkg::EV_ALR_OFF] & ~alarm_d & start_alarm;
      inhibit_raise_event <= evt_en_q[fsl_pkg::EV_INH_ON] & inhibit_d & ~start_inhibit;
      inhibit_clear_event <= evt_en_q[fsl_pkg::EV_INH_OFF] & ~inhibit_d & start_inhibit;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence start_s;
    start_evt && interval_q != 8'h0 && !min_tick;
  endsequence
  sequence inhibit_s;
    ##2 start_inhibit;
  endsequence

  start_detect_a: assert property ($fell(stopped_q) |-> $past(start_evt))
    else $error("motor left stopped state without a start");
  stop_detect_a: assert property (below && !start_evt |=> stopped_q)
    else $error("low current did not stop motor");
  alarm_raise_a: assert property (alarm_set |=> start_alarm ##1 hourly_cnt == max_w - 5'h1)
    else $error("alarm not raised on next-to-last start");
  start_inhibit_a: assert property (en_q ##0 start_s |-> inhibit_s)
    else $error("inhibit missing after start");
  lockout_hold_a: assert property (lock_q && en_q && !wr_ctrl |=> start_inhibit)
    else $error("inhibit dropped during hourly lockout");
  force_clear_a: assert property (force_exp && !wr_ctrl |=> !force_flag)
    else $error("force flag did not clear");
  hourly_count_a: assert property (start_evt && !min_tick && |alloc
                                   |=> hourly_cnt == $past(hourly_cnt) + 5'h1)
    else $error("hourly count not advanced");
  elapsed_reset_a: assert property (start_evt |=> since_q == 16'h0)
    else $error("elapsed time not restarted");
  total_count_a: assert property (start_evt |=> total_q == $past(total_q) + 32'h1)
    else $error("total start count wrong");
  trip_record_a: assert property (trip_in |=> trip_ts_q == $past(trip_stamp))
    else $error("trip timestamp not recorded");
  inhibit_event_a: assert property ($rose(start_inhibit) && evt_en_q[2] |-> inhibit_raise_event)
    else $error("inhibit raise event missing");
endmodule

// ==== test/fsl_motor_model.sv ====
`timescale 1ns/1ps
// motor and breaker: the breaker close is refused while the start inhibit stands
module fsl_motor_model (
  // clock
  input wire logic hclk,
  // close request and interlock
  input wire logic run_req,
  input wire logic start_inhibit,
  // measured current
  output logic [15:0] phase_current
);
  logic running_q = 1'b0;
  logic running_d;

  // an inhibit blocks a close, but never trips a motor already running
  assign running_d = run_req & (running_q | ~start_inhibit);
  assign phase_current = running_q ? 16'h0700 : 16'h0000;

  // breaker state
  always_ff @(posedge hclk)
  begin
    running_q <= running_d;
  end
endmodule

// ==== test/fsl_top_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t %s got %h exp %h", $time, m, a, b); end end
module fsl_top_test;
  // bench signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [15:0] phase_current;
  logic trip_in = 1'b0;
  logic [31:0] trip_stamp = 32'h0;
  logic panel_button = 1'b0;
  logic run_req = 1'b0;
  logic start_alarm, start_inhibit, force_flag;
  logic alarm_on_event, alarm_off_event, inhibit_raise_event, inhibit_clear_event;
  int n_errors = 0;
  int compares = 0;
  int n_aon = 0, n_aoff = 0, n_iraise = 0, n_iclear = 0;
  int n, m;
  time t0;
  logic [31:0] r;
  logic [7:0] ra [9] = '{fsl_pkg::A_CTRL, fsl_pkg::A_MAX, fsl_pkg::A_INTERVAL,
    fsl_pkg::A_THRESH, fsl_pkg::A_NOMINAL, fsl_pkg::A_EVT_EN, fsl_pkg::A_STATUS,
    fsl_pkg::A_TOTAL, 8'h2c};
  logic [31:0] rv [9] = '{32'h1, 32'(fsl_pkg::MAX_RST), 32'(fsl_pkg::INTERVAL_RST),
    32'(fsl_pkg::THRESH_RST), 32'(fsl_pkg::NOMINAL_RST), 32'(fsl_pkg::EVT_EN_RST),
    32'h0, 32'h0, 32'h0};

  // one minute is 20 cycles so an hour fits in the run
  localparam int MINC = 20;
  fsl_top #(.MIN_CYC(MINC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_current(phase_current),
    .trip_in(trip_in), .trip_stamp(trip_stamp), .panel_button(panel_button),
    .start_alarm(start_alarm), .start_inhibit(start_inhibit), .force_flag(force_flag),
    .alarm_on_event(alarm_on_event), .alarm_off_event(alarm_off_event),
    .inhibit_raise_event(inhibit_raise_event), .inhibit_clear_event(inhibit_clear_event));

  fsl_motor_model motor (.hclk(hclk), .run_req(run_req), .start_inhibit(start_inhibit),
    .phase_current(phase_current));

  always #2 hclk = ~hclk;

  // event pulse counters; the falling edge keeps them settled before checks at the rising edge
  always @(negedge hclk)
  begin
    if (alarm_on_event === 1'b1) n_aon++;
    if (alarm_off_event === 1'b1) n_aoff++;
    if (inhibit_raise_event === 1'b1) n_iraise++;
    if (inhibit_clear_event === 1'b1) n_iclear++;
  end

  // single ahb-lite transfer; address held until hready, data held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // wait for the inhibit level, bounded
  task automatic wait_inh(input logic lvl, input int lim, output int k);
    k = 0;
    while (start_inhibit !== lvl && k < lim)
    begin
      @(posedge hclk);
      k++;
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog: the whole sequence takes under 4000 cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict;
  end

  initial
  begin
    repeat (2) @(posedge hclk);
    `CHK(hreadyout, 1'b1, "hreadyout in reset")
    `CHK(hresp, 1'b0, "hresp in reset")
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    // register reset values, unmapped offset last
    for (int i = 0; i < 9; i++)
    begin
      ahb(1'b0, ra[i], 32'h0, r);
      `CHK(r, rv[i], "reset value")
    end
    $display("test reset_values done");

    // short interval, inhibit raise event disabled
    ahb(1'b1, 8'h08, 32'h2, r);
    ahb(1'b1, 8'h14, 32'hb, r);
    // first start: inhibit for the interval, alarm still off
    run_req <= 1'b1;
    wait_inh(1'b1, 10, n);
    t0 = $time;
    `CHK(start_inhibit, 1'b1, "inhibit after start")
    `CHK(start_alarm, 1'b0, "alarm on first start")
    `CHK(n_iraise, 0, "raise event disabled")
    ahb(1'b0, 8'h1c, 32'h0, r);
    `CHK(r, 32'h1, "total after first")
    ahb(1'b0, 8'h18, 32'h0, r);
    `CHK(r[12:8], 5'h1, "hourly after first")
    `CHK(r[0], 1'b1, "running")
    run_req <= 1'b0;
    repeat (3) @(posedge hclk);
    ahb(1'b0, 8'h18, 32'h0, r);
    `CHK(r[0], 1'b0, "stopped")
    wait_inh(1'b0, 100, m);
    n = int'(($time - t0) / 4);
    `CHK(n >= MINC && n <= 2 * MINC + 1, 1'b1, "interval length")
    `CHK(n_iclear, 1, "clear event")
    ahb(1'b0, 8'h20, 32'h0, r);
    `CHK(r[15:0] >= 1 && r[15:0] <= 2, 1'b1, "elapsed minutes")
    $display("test first_start done");

    // second start is the next-to-last one
    run_req <= 1'b1;
    wait_inh(1'b1, 10, n);
    `CHK(start_alarm, 1'b1, "alarm on next-to-last")
    `CHK(n_aon, 1, "alarm on event")
    run_req <= 1'b0;
    wait_inh(1'b0, 100, m);
    $display("test second_start done");

    // third start reaches the limit: alarm off, hour lockout
    run_req <= 1'b1;
    wait_inh(1'b1, 10, n);
    t0 = $time;
    repeat (2) @(posedge hclk);
    `CHK(start_alarm, 1'b0, "alarm off at limit")
    `CHK(n_aoff, 1, "alarm off event")
    ahb(1'b0, 8'h18, 32'h0, r);
    `CHK(r[12:8], 5'h3, "hourly count three")
    run_req <= 1'b0;
    repeat (60) @(posedge hclk);
    `CHK(start_inhibit, 1'b1, "lockout beyond interval")
    wait_inh(1'b0, 1300, m);
    n = int'(($time - t0) / 4);
    `CHK(n >= 59 * MINC && n <= 60 * MINC + 1, 1'b1, "lockout length")
    repeat (4) @(posedge hclk);
    ahb(1'b0, 8'h18, 32'h0, r);
    `CHK(r[12:8], 5'h0, "hourly aged out")
    ahb(1'b0, 8'h1c, 32'h0, r);
    `CHK(r, 32'h3, "total kept")
    $display("test lockout done");

    // trip record
    trip_stamp <= 32'h5a1c_3e07;
    trip_in <= 1'b1;
    @(posedge hclk);
    trip_in <= 1'b0;
    ahb(1'b0, 8'h24, 32'h0, r);
    `CHK(r, 32'h5a1c_3e07, "trip stamp")
    ahb(1'b0, 8'h28, 32'h0, r);
    `CHK(r[4:0], 5'h0, "trip hourly count")
    `CHK(r[31:16] >= 59 && r[31:16] <= 61, 1'b1, "trip elapsed")
    $display("test trip done");

    // force flag: a panel press restarts the five minute timer
    ahb(1'b1, 8'h00, 32'h3, r);
    repeat (2) @(posedge hclk);
    `CHK(force_flag, 1'b1, "force set")
    repeat (60) @(posedge hclk);
    panel_button <= 1'b1;
    repeat (4) @(posedge hclk);
    panel_button <= 1'b0;
    repeat (60) @(posedge hclk);
    `CHK(force_flag, 1'b1, "force kept by press")
    repeat (80) @(posedge hclk);
    `CHK(force_flag, 1'b0, "force expired")
    ahb(1'b0, 8'h18, 32'h0, r);
    `CHK(r[3], 1'b0, "force status")
    $display("test force done");

    // mid-run reset: counters and settings go back to their reset values
    hresetn <= 1'b0;
    @(posedge hclk);
    `CHK(hrdata, 32'h0, "hrdata in reset")
    hresetn <= 1'b1;
    ahb(1'b0, 8'h1c, 32'h0, r);
    `CHK(r, 32'h0, "total after reset")
    ahb(1'b0, 8'h08, 32'h0, r);
    `CHK(r, 32'(fsl_pkg::INTERVAL_RST), "interval after reset")
    $display("test mid_reset done");

    // max of two: the first start is next-to-last, and the alarm ends after the hour
    ahb(1'b1, 8'h04, 32'h2, r);
    run_req <= 1'b1;
    wait_inh(1'b1, 10, n);
    t0 = $time;
    `CHK(start_alarm, 1'b1, "alarm with max two")
    `CHK(n_iraise, 1, "raise event enabled")
    run_req <= 1'b0;
    m = 0;
    while (start_alarm === 1'b1 && m < 1300)
    begin
      @(posedge hclk);
      m++;
    end
    n = int'(($time - t0) / 4);
    `CHK(n >= 59 * MINC && n <= 60 * MINC + 1, 1'b1, "alarm hour")
    `CHK(n_aoff, 2, "alarm off event after hour")
    $display("test alarm_hour done");
    give_verdict;
  end
endmodule
